// ==== rx_uart_defines.vh ====
`ifndef RX_UART_DEFINES_VH
`define RX_UART_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define REG_DATA        3'h0
`define REG_STATUS_A    3'h1
`define REG_CONTROL_B   3'h2
`define REG_CONTROL_C   3'h3
`define REG_BAUD        3'h4
`define REG_LAST        3'h4

// ----------------------------------------------------------------
// serial_status_a fields
// ----------------------------------------------------------------
`define STA_RXC         7
`define STA_FE          4
`define STA_DOR         3
`define STA_UPE         2

// ----------------------------------------------------------------
// serial_control_b fields
// ----------------------------------------------------------------
`define CTB_RX_COMPLETE_IRQ_ENABLE       7
`define CTB_RECEIVER_ENABLE        4
`define CTB_CSZ2        2
`define CTB_RX_NINTH_BIT        1
`define CTB_TX_NINTH_BIT        0

// ----------------------------------------------------------------
// serial_control_c fields
// ----------------------------------------------------------------
`define CTC_PARITY_ENABLE_BIT        5
`define CTC_PARITY_ODD_SELECT        4
`define CTC_STOP_BIT_COUNT_SELECT        3
`define CTC_CSZ_HI      2
`define CTC_CSZ_LO      1

// ----------------------------------------------------------------
// fifo entry layout
// ----------------------------------------------------------------
`define ENT_W           12
`define ENT_UPE         11
`define ENT_DOR         10
`define ENT_FE          9
`define ENT_D9          8

// ----------------------------------------------------------------
// codes, reset values, responses
// ----------------------------------------------------------------
`define CSZ_NINE        3'h7
`define CSZ_RST         3'h3
`define BAUD_RST        16'h0015
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define DATA_BITS_MIN   4'h5

`endif

// ==== rx_pair_fifo.v ====
`include "rx_uart_defines.vh"

module rx_pair_fifo (
   input  wire                 clk,
   input  wire                 rst_n,
   input  wire                 flush,
   input  wire                 push,
   input  wire [`ENT_W-1:0]    push_entry,
   input  wire                 pop,
   output wire [`ENT_W-1:0]    head_entry,
   output wire                 empty,
   output wire                 full
);

   reg [`ENT_W-1:0] mem [0:1];
   reg              wr_ptr_q;
   reg              rd_ptr_q;
   reg [1:0]        count_q;
   wire             do_pop;
   wire             do_push;

   assign empty      = (count_q == 2'h0);
   assign full       = (count_q == 2'h2);
   assign do_pop     = pop & ~empty;
   assign do_push    = push & (~full | do_pop);
   assign head_entry = mem[rd_ptr_q];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr_q] <= push_entry;
      end
   end

   // ----------------------------------------------------------------
   // pointers and fill count
   // ----------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end else if (flush) begin
         wr_ptr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         count_q  <= 2'h0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (do_pop) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         if (do_push & ~do_pop) begin
            count_q <= count_q + 2'h1;
         end else if (do_pop & ~do_push) begin
            count_q <= count_q - 2'h1;
         end
      end
   end

endmodule // rx_pair_fifo

// ==== rx_uart_core.v ====
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`include "rx_uart_defines.vh"

// Summary of operation
// (R1) nine-bit mode: software reads ninth bit first
// (R2) data read pops fifo, status follows
// (R3) receive-complete high while fifo nonempty
// (R4) receiver disable flushes fifo
// (R5) irq level: flag, enable, global enable
// (R6) isr must read data to clear
// (R7) error flags stored per entry, read-only
// (R8) error flags raise no interrupt
// (R9) software writes zero to error bits
// (R10) frame error is inverted first stop
// (R11) only first stop bit checked
// (R12) overrun on start with fifo full, held
// (R13) overrun clears on successful transfer
// (R14) parity on when upper bit; lower selects odd
// (R15) parity mismatch stored in entry
// (R16) parity error zero while parity off
// (R17) parity error valid until data read
// (R18) disable abandons frame, releases pin
// (R19) flush by reading until flag clear
// (R20) first stop moves frame to fifo
// (R21) unused upper data bits read zero
// (R22) enable takes over receive pin
// (R23) freed slot takes held frame at once
// (R24) status read has no fifo effect

module rx_uart_core (
   input  wire        SYS_CLK,
   input  wire        RST_B,
   input  wire        RXD,
   input  wire        GLOBAL_IRQ_EN,
   output wire        RX_PIN_OVERRIDE,
   output wire        RX_IRQ,
   input  wire [31:0] S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output wire        S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output wire        S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [31:0] S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output wire        S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY
);

   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_START = 2'h1;
   localparam [1:0] ST_BITS  = 2'h2;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function mapped;
      input [31:0] addr;
      begin
         mapped = (addr[31:5] == 27'h0) && (addr[4:2] <= `REG_LAST);
      end
   endfunction

   function [7:0] data_mask;
      input [2:0] csz;
      begin
         case (csz)
            3'h0:    data_mask = 8'h1F;
            3'h1:    data_mask = 8'h3F;
            3'h2:    data_mask = 8'h7F;
            default: data_mask = 8'hFF;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   reg rst_meta_q;
   reg rst_n;

   always @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_meta_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n      <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   reg        rx_complete_irq_enable_q;
   reg        receiver_enable_q;
   reg        tx_ninth_bit_q;
   reg [2:0]  csz_q;
   reg [1:0]  upm_q;
   reg        stop_bit_count_select_q;
   reg [15:0] baud_q;

   wire       pen = upm_q[1];                            // R14
   wire       odd = upm_q[0];                            // R14
   wire [3:0] n_data = (csz_q == `CSZ_NINE) ? 4'h9 :
                       `DATA_BITS_MIN + {2'h0, csz_q[1:0]};
   wire [3:0] n_total = n_data + {3'h0, pen};

   // ----------------------------------------------------------------
   // fifo
   // ----------------------------------------------------------------
   wire [`ENT_W-1:0] head;
   wire              f_empty;
   wire              f_full;
   wire              pop;
   reg               hold_valid_q;
   reg [`ENT_W-1:0]  hold_q;
   reg               ovr_q;

   rx_pair_fifo u_fifo (
      .clk        (SYS_CLK),
      .rst_n      (rst_n),
      .flush      (~receiver_enable_q),                             // R4
      .push       (hold_valid_q),                        // R20 R23
      .push_entry ({hold_q[`ENT_UPE],                   // R12
                    hold_q[`ENT_DOR] | ovr_q,
                    hold_q[`ENT_FE:0]}),
      .pop        (pop),                                 // R2
      .head_entry (head),
      .empty      (f_empty),
      .full       (f_full)
   );

   wire rx_complete_flag = ~f_empty;                                  // R3
   wire take = hold_valid_q & (~f_full | pop);           // R23

   assign RX_IRQ          = rx_complete_flag & rx_complete_irq_enable_q & GLOBAL_IRQ_EN; // R5 R8
   assign RX_PIN_OVERRIDE = receiver_enable_q;                      // R18 R22

   // ----------------------------------------------------------------
   // receive sequencer
   // ----------------------------------------------------------------
   reg [1:0]  state_q;
   reg [15:0] cnt_q;
   reg [3:0]  idx_q;
   reg [8:0]  shift_q;
   reg        par_q;
   reg        rx_prev_q;

   wire [15:0] limit = (state_q == ST_START) ? {1'b0, baud_q[15:1]}
                                             : baud_q;
   wire        tick  = (cnt_q == limit);
   wire        start_edge = rx_prev_q & ~RXD;
   wire        upe_new = pen & (^shift_q ^ par_q ^ odd);  // R15

   always @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q      <= ST_IDLE;
         cnt_q        <= 16'h0000;
         idx_q        <= 4'h0;
         shift_q      <= 9'h000;
         par_q        <= 1'b0;
         rx_prev_q    <= 1'b1;
         ovr_q        <= 1'b0;
         hold_valid_q <= 1'b0;
         hold_q       <= {`ENT_W{1'b0}};
      end else if (!receiver_enable_q) begin
         state_q      <= ST_IDLE;                        // R18
         cnt_q        <= 16'h0000;
         rx_prev_q    <= 1'b1;
         ovr_q        <= 1'b0;
         hold_valid_q <= 1'b0;
      end else begin
         rx_prev_q <= RXD;
         if (take) begin
            hold_valid_q <= 1'b0;
            ovr_q        <= 1'b0;                        // R13
         end
         case (state_q)
            ST_IDLE: begin
               cnt_q <= 16'h0000;
               if (start_edge) begin
                  state_q <= ST_START;
                  if (f_full & hold_valid_q & ~take) begin
                     ovr_q <= 1'b1;                      // R12
                  end
               end
            end
            ST_START: begin
               cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
               if (tick) begin
                  idx_q   <= 4'h0;
                  shift_q <= 9'h000;
                  state_q <= RXD ? ST_IDLE : ST_BITS;
               end
            end
            ST_BITS: begin
               cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
               if (tick) begin
                  idx_q <= idx_q + 4'h1;
                  if (idx_q < n_data) begin
                     shift_q[idx_q] <= RXD;
                  end else if (idx_q < n_total) begin
                     par_q <= RXD;
                  end else begin
                     // first stop bit ends the frame
                     state_q <= ST_IDLE;                 // R11 R20
                     if (~hold_valid_q | take) begin
                        hold_valid_q <= 1'b1;
                        hold_q <= {upe_new,              // R15 R7
                                   ovr_q & ~take,
                                   ~RXD,                 // R10
                                   shift_q};
                     end
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   reg        aw_full_q;
   reg [31:0] aw_addr_q;
   reg        w_full_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;

   assign S_AXI_AWREADY = ~aw_full_q;
   assign S_AXI_WREADY  = ~w_full_q;

   wire do_wr = aw_full_q & w_full_q & ~S_AXI_BVALID;
   wire wr_ok = mapped(aw_addr_q);

   always @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q    <= 1'b0;
         aw_addr_q    <= 32'h00000000;
         w_full_q     <= 1'b0;
         w_data_q     <= 32'h00000000;
         w_strb_q     <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= `RESP_OKAY;
         rx_complete_irq_enable_q      <= 1'b0;
         receiver_enable_q       <= 1'b0;
         tx_ninth_bit_q       <= 1'b0;
         csz_q        <= `CSZ_RST;
         upm_q        <= 2'h0;
         stop_bit_count_select_q       <= 1'b0;
         baud_q       <= `BAUD_RST;
      end else begin
         if (S_AXI_AWVALID & ~aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & ~w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (S_AXI_BVALID & S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
         if (do_wr) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_ok & w_strb_q[0]) begin
               // status writes leave error flags untouched
               case (aw_addr_q[4:2])                     // R7 R9
                  `REG_CONTROL_B: begin
                     rx_complete_irq_enable_q  <= w_data_q[`CTB_RX_COMPLETE_IRQ_ENABLE];
                     receiver_enable_q   <= w_data_q[`CTB_RECEIVER_ENABLE];    // R4 R22
                     csz_q[2] <= w_data_q[`CTB_CSZ2];
                     tx_ninth_bit_q   <= w_data_q[`CTB_TX_NINTH_BIT];
                  end
                  `REG_CONTROL_C: begin
                     upm_q      <= w_data_q[`CTC_PARITY_ENABLE_BIT:`CTC_PARITY_ODD_SELECT];
                     stop_bit_count_select_q     <= w_data_q[`CTC_STOP_BIT_COUNT_SELECT];
                     csz_q[1:0] <= w_data_q[`CTC_CSZ_HI:`CTC_CSZ_LO];
                  end
                  `REG_BAUD: begin
                     baud_q[7:0] <= w_data_q[7:0];
                  end
                  default: begin
                  end
               endcase
            end
            if (wr_ok & w_strb_q[1] & (aw_addr_q[4:2] == `REG_BAUD)) begin
               baud_q[15:8] <= w_data_q[15:8];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign S_AXI_ARREADY = ~S_AXI_RVALID;

   wire ar_go = S_AXI_ARVALID & ~S_AXI_RVALID;
   wire rd_ok = mapped(S_AXI_ARADDR);

   // only a data read advances the fifo
   assign pop = ar_go & rd_ok &
                (S_AXI_ARADDR[4:2] == `REG_DATA);        // R2 R24

   reg [7:0] rd_byte;

   always @* begin
      rd_byte = 8'h00;
      case (S_AXI_ARADDR[4:2])
         `REG_DATA: begin
            rd_byte = head[7:0] & data_mask(csz_q) &
                      {8{rx_complete_flag}};                          // R21
         end
         `REG_STATUS_A: begin
            rd_byte[`STA_RXC] = rx_complete_flag;                     // R3
            rd_byte[`STA_FE]  = rx_complete_flag & head[`ENT_FE];     // R10
            rd_byte[`STA_DOR] = rx_complete_flag & head[`ENT_DOR];    // R12
            rd_byte[`STA_UPE] = rx_complete_flag & pen &
                                head[`ENT_UPE];          // R16 R17
         end
         `REG_CONTROL_B: begin
            rd_byte[`CTB_RX_COMPLETE_IRQ_ENABLE] = rx_complete_irq_enable_q;
            rd_byte[`CTB_RECEIVER_ENABLE]  = receiver_enable_q;
            rd_byte[`CTB_CSZ2]  = csz_q[2];
            rd_byte[`CTB_RX_NINTH_BIT]  = rx_complete_flag & head[`ENT_D9];   // R1
            rd_byte[`CTB_TX_NINTH_BIT]  = tx_ninth_bit_q;
         end
         `REG_CONTROL_C: begin
            rd_byte[`CTC_PARITY_ENABLE_BIT:`CTC_PARITY_ODD_SELECT]   = upm_q;
            rd_byte[`CTC_STOP_BIT_COUNT_SELECT]             = stop_bit_count_select_q;
            rd_byte[`CTC_CSZ_HI:`CTC_CSZ_LO] = csz_q[1:0];
         end
         `REG_BAUD: begin
            rd_byte = baud_q[7:0];
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   always @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h00000000;
         S_AXI_RRESP  <= `RESP_OKAY;
      end else begin
         if (S_AXI_RVALID & S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
         if (ar_go) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (!rd_ok) begin
               S_AXI_RDATA <= 32'h00000000;
            end else if (S_AXI_ARADDR[4:2] == `REG_BAUD) begin
               S_AXI_RDATA <= {16'h0000, baud_q};
            end else begin
               S_AXI_RDATA <= {24'h000000, rd_byte};
            end
         end
      end
   end

endmodule // rx_uart_core

// ==== rx_uart_core_assertions.sv ====
`include "rx_uart_defines.vh"

module rx_uart_checker (
   input wire        SYS_CLK,
   input wire        RST_B,
   input wire        GLOBAL_IRQ_EN,
   input wire        RX_PIN_OVERRIDE,
   input wire        RX_IRQ,
   input wire        S_AXI_AWVALID,
   input wire        S_AXI_AWREADY,
   input wire        S_AXI_WVALID,
   input wire        S_AXI_WREADY,
   input wire        S_AXI_BVALID,
   input wire [31:0] S_AXI_ARADDR,
   input wire        S_AXI_ARVALID,
   input wire        S_AXI_ARREADY,
   input wire [31:0] S_AXI_RDATA,
   input wire [1:0]  S_AXI_RRESP,
   input wire        S_AXI_RVALID
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
   wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY;

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   property p_irq_gate; !GLOBAL_IRQ_EN |-> !RX_IRQ; endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
   property p_flush; !RX_PIN_OVERRIDE [*3] |-> !RX_IRQ; endproperty
   a_flush: assert property (p_flush) else $error("irq after disable");
   property p_stat_keep;
      ar_hs && S_AXI_ARADDR == 32'h4 && RX_IRQ && RX_PIN_OVERRIDE
      && !S_AXI_AWVALID && !S_AXI_BVALID |=> RX_IRQ || !GLOBAL_IRQ_EN;
   endproperty
   a_stat_keep: assert property (p_stat_keep) else $error("status pop");
   property p_rd_lat; ar_hs |=> S_AXI_RVALID; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read late");
   property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
   a_ar_block: assert property (p_ar_block) else $error("ar ready");
   property p_wr_resp; aw_hs |-> ##[1:2] S_AXI_BVALID; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("no write resp");
   property p_rd_err;
      ar_hs && S_AXI_ARADDR[31:5] != 27'h0 |=>
      S_AXI_RRESP == `RESP_SLVERR && S_AXI_RDATA == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read");
   property p_rd_ok;
      ar_hs && S_AXI_ARADDR == 32'h8 |=> S_AXI_RRESP == `RESP_OKAY;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("mapped read resp");

   c_irq: cover property ($rose(RX_IRQ));
   c_err: cover property (ar_hs && S_AXI_ARADDR[31:5] != 27'h0);
   c_off: cover property ($fell(RX_PIN_OVERRIDE));
endmodule // rx_uart_checker

bind rx_uart_core rx_uart_checker i_chk (
   .SYS_CLK, .RST_B, .GLOBAL_IRQ_EN, .RX_PIN_OVERRIDE, .RX_IRQ,
   .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BVALID, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
   .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID);

// ==== serial_line_model.sv ====
module serial_line_model #(
   parameter int BIT_CYC = 4
) (
   input  wire logic clk,
   output logic      rxd
);
   timeunit 1ns;
   timeprecision 1ps;

   initial rxd = 1'b1;

   task automatic put(input logic v);
      rxd <= v;
      repeat (BIT_CYC) @(posedge clk);
   endtask

   // start, data lsb first, optional parity, first stop, idle high
   task automatic send(input logic [8:0] d, input int nb, input logic pe,
                       input logic pb, input logic stop);
      put(1'b0);
      for (int i = 0; i < nb; i++) put(d[i]);
      if (pe) put(pb);
      put(stop);
      put(1'b1);
   endtask
endmodule // serial_line_model

// ==== tb.sv ====
`include "rx_uart_defines.vh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          BAUD  = 3;
   localparam logic [31:0] A_DAT = 32'h00;
   localparam logic [31:0] A_STA = 32'h04;
   localparam logic [31:0] A_CB  = 32'h08;
   localparam logic [31:0] A_CC  = 32'h0C;
   localparam logic [31:0] A_BD  = 32'h10;
   logic        SYS_CLK       = 1'b0;
   logic        RST_B         = 1'b0;
   logic        GLOBAL_IRQ_EN = 1'b1;
   logic        S_AXI_AWVALID = 1'b0;
   logic        S_AXI_WVALID  = 1'b0;
   logic        S_AXI_BREADY  = 1'b0;
   logic        S_AXI_ARVALID = 1'b0;
   logic        S_AXI_RREADY  = 1'b0;
   logic [31:0] S_AXI_AWADDR  = 32'h0;
   logic [31:0] S_AXI_WDATA   = 32'h0;
   logic [31:0] S_AXI_ARADDR  = 32'h0;
   logic [3:0]  S_AXI_WSTRB   = 4'hF;
   wire         RXD, RX_PIN_OVERRIDE, RX_IRQ, S_AXI_AWREADY, S_AXI_WREADY;
   wire         S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   wire  [31:0] S_AXI_RDATA;
   logic [31:0] d;
   logic [1:0]  r;
   int          fails       = 0;
   int          comparisons = 0;
   int          cyc         = 0;

   always #12.5 SYS_CLK = ~SYS_CLK;

   serial_line_model #(.BIT_CYC(BAUD + 1)) i_tx (.clk(SYS_CLK), .rxd(RXD));

   rx_uart_core i_dut (
      .SYS_CLK, .RST_B, .RXD, .GLOBAL_IRQ_EN, .RX_PIN_OVERRIDE, .RX_IRQ,
      .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
      .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
      .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
      .S_AXI_RREADY);

   // ---------------------------------------------------------------
   // bus and check helpers
   // ---------------------------------------------------------------
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= v;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      r = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
      @(posedge SYS_CLK);
   endtask

   task automatic rd(input logic [31:0] a);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      d = S_AXI_RDATA;
      r = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
      @(posedge SYS_CLK);
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rdchk(input logic [31:0] a, e, input string n);
      rd(a);
      chk(n, e, d);
   endtask

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      rdchk(A_CC, 32'h06, "ctl_c_rst");
      rdchk(A_BD, 32'h15, "baud_rst");
      rdchk(A_CB, 32'h00, "ctl_b_rst");
      rdchk(A_STA, 32'h00, "stat_rst");
      rdchk(32'h20, 32'h00, "bad_rd");
      chk("bad_rd_resp", `RESP_SLVERR, r);
      wr(32'h20, 32'hFF);
      chk("bad_wr_resp", `RESP_SLVERR, r);
      S_AXI_WSTRB <= 4'h2;
      wr(A_BD, 32'hFF03);
      rdchk(A_BD, 32'hFF15, "strobe");
      S_AXI_WSTRB <= 4'hF;
      wr(A_BD, BAUD);
      wr(A_CB, 32'h90);
      chk("pin_owner", 1, RX_PIN_OVERRIDE);
      done("regs");
   endtask

   task automatic t_basic();
      i_tx.send(9'h0A5, 8, 0, 0, 1);
      chk("irq", 1, RX_IRQ);
      GLOBAL_IRQ_EN <= 1'b0;
      rdchk(A_STA, 32'h80, "rxc");
      chk("irq_gated", 0, RX_IRQ);
      rdchk(A_STA, 32'h80, "rxc_again");
      GLOBAL_IRQ_EN <= 1'b1;
      rdchk(A_DAT, 32'hA5, "data");
      chk("irq_drain", 0, RX_IRQ);
      rdchk(A_STA, 32'h00, "rxc_clear");
      done("basic");
   endtask

   task automatic t_frame();
      wr(A_CC, 32'h0E);
      i_tx.send(9'h03C, 8, 0, 0, 0);
      i_tx.send(9'h0C3, 8, 0, 0, 1);
      wr(A_STA, 32'h00);
      rdchk(A_STA, 32'h90, "frame_err");
      rdchk(A_DAT, 32'h3C, "data_fe");
      rdchk(A_STA, 32'h80, "fe_next");
      rdchk(A_DAT, 32'hC3, "data_ok");
      done("frame");
   endtask

   task automatic t_parity();
      for (int i = 0; i < 4; i++) begin
         wr(A_CC, {26'h0, 1'b1, i[0], 4'h6});
         i_tx.send(9'h05A, 8, 1, i[0] ^ i[1], 1);
         rdchk(A_STA, {24'h0, 5'h10, i[1], 2'h0}, "parity");
         rdchk(A_STA, {24'h0, 5'h10, i[1], 2'h0}, "par_hold");
         rdchk(A_DAT, 32'h5A, "par_data");
      end
      wr(A_CC, 32'h16);
      i_tx.send(9'h007, 8, 0, 0, 1);
      rdchk(A_STA, 32'h80, "par_off");
      rdchk(A_DAT, 32'h07, "par_off_data");
      done("parity");
   endtask

   task automatic t_overrun();
      wr(A_CC, 32'h06);
      for (int i = 1; i < 5; i++) i_tx.send(9'(i), 8, 0, 0, 1);
      for (int i = 1; i < 4; i++) begin
         rdchk(A_STA, (i == 3) ? 32'h88 : 32'h80, "ovr");
         rdchk(A_DAT, i, "ovr_data");
      end
      rdchk(A_STA, 32'h00, "drained");
      i_tx.send(9'h055, 8, 0, 0, 1);
      rdchk(A_STA, 32'h80, "ovr_clear");
      rdchk(A_DAT, 32'h55, "data_after");
      done("overrun");
   endtask

   task automatic t_size();
      wr(A_CB, 32'h94);
      i_tx.send(9'h1A5, 9, 0, 0, 1);
      rdchk(A_CB, 32'h96, "ninth");
      rdchk(A_DAT, 32'hA5, "low8");
      wr(A_CB, 32'h90);
      wr(A_CC, 32'h00);
      i_tx.send(9'h1F5, 5, 0, 0, 1);
      rdchk(A_DAT, 32'h15, "five");
      done("size");
   endtask

   task automatic t_disable();
      wr(A_CC, 32'h06);
      i_tx.send(9'h011, 8, 0, 0, 1);
      fork
         i_tx.send(9'h022, 8, 0, 0, 1);
         begin
            repeat (12) @(posedge SYS_CLK);
            wr(A_CB, 32'h80);
         end
      join
      chk("pin_free", 0, RX_PIN_OVERRIDE);
      rdchk(A_STA, 32'h00, "flushed");
      wr(A_CB, 32'h90);
      rdchk(A_STA, 32'h00, "no_stale");
      done("disable");
   endtask

   task automatic print_verdict();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   always @(posedge SYS_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails++;
         print_verdict();
      end
   end

   initial begin
      repeat (12) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      repeat (3) @(posedge SYS_CLK);
      t_regs();
      t_basic();
      t_frame();
      t_parity();
      t_overrun();
      t_size();
      t_disable();
      print_verdict();
   end
endmodule // tb
